// *** src/tcs_top.sv ***
// Torque command selector with control mode switching and AHB-Lite registers
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/10ps
module tcs_top
  import tcs_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic torque_source_sel0,
  input wire logic torque_source_sel1,
  input wire logic speed_source_sel0,
  input wire logic speed_source_sel1,
  input wire logic mode_switch_in,
  input wire logic signed [15:0] analog_torque_in,
  input wire logic signed [15:0] analog_speed_in,
  output logic signed [15:0] torque_cmd,
  output logic torque_is_limit,
  output logic signed [15:0] speed_cmd,
  output logic pulse_position_active,
  output logic [1:0] active_loop
);
  // Synchronised digital inputs
  logic [4:0] pins_raw;
  logic [4:0] pins_s;
  assign pins_raw = {mode_switch_in, speed_source_sel1, speed_source_sel0,
                     torque_source_sel1, torque_source_sel0};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      tcs_sync u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .din(pins_raw[gi]),
        .dout(pins_s[gi])
      );
    end
  endgenerate

  logic [1:0] tsel;
  logic [1:0] ssel;
  logic sw_on;
  assign tsel = pins_s[1:0];
  assign ssel = pins_s[3:2];
  assign sw_on = pins_s[4];

  // Registers
  logic [15:0] full_scale_ff;
  logic [15:0] trq1_ff, trq2_ff, trq3_ff;
  logic [15:0] speed_source_sel1_ff, spd2_ff, spd3_ff;
  logic [7:0] mode_ff;
  logic [3:0] lpf_ff;
  logic [15:0] nxt_full_scale;
  logic [15:0] nxt_trq1, nxt_trq2, nxt_trq3;
  logic [15:0] nxt_speed_source_sel1, nxt_spd2, nxt_spd3;
  logic [7:0] nxt_mode;
  logic [3:0] nxt_lpf;

  // AHB-Lite address phase capture
  logic wr_pend_ff;
  logic [11:0] wr_idx_ff;
  logic [31:0] hrdata_ff;
  logic nxt_wr_pend;
  logic [11:0] nxt_wr_idx;
  logic [31:0] nxt_hrdata;
  logic addr_ok;
  logic [11:0] a_idx;
  logic [31:0] rd_val;
  logic signed [15:0] wval;
  logic signed [15:0] torque_out_ff;
  logic [1:0] loop_cur;

  assign addr_ok = hsel && hready && htrans[1];
  assign a_idx = haddr[13:2];
  assign wval = hwdata[15:0];

  function automatic logic [15:0] clamp_trq(input logic signed [15:0] v);
    if (v > TCS_TRQ_LIMIT) return TCS_TRQ_LIMIT;
    if (v < -TCS_TRQ_LIMIT) return -TCS_TRQ_LIMIT;
    return v;
  endfunction : clamp_trq

  function automatic logic mode_legal(input logic [7:0] m);
    // Zero-command variants are single modes only; no dual code uses them
    return m inside {TCS_MODE_PT, TCS_MODE_S, TCS_MODE_T, TCS_MODE_SZ,
                     TCS_MODE_TZ, TCS_MODE_PT_S, TCS_MODE_PT_T, TCS_MODE_S_T};
  endfunction : mode_legal

  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (a_idx)
      TCS_IDX_FULL_SCALE: rd_val = {16'h0000, full_scale_ff};
      TCS_IDX_TRQ_CMD_1: rd_val = {{16{trq1_ff[15]}}, trq1_ff};
      TCS_IDX_TRQ_CMD_2: rd_val = {{16{trq2_ff[15]}}, trq2_ff};
      TCS_IDX_TRQ_CMD_3: rd_val = {{16{trq3_ff[15]}}, trq3_ff};
      TCS_IDX_SPD_CMD_1: rd_val = {{16{speed_source_sel1_ff[15]}}, speed_source_sel1_ff};
      TCS_IDX_SPD_CMD_2: rd_val = {{16{spd2_ff[15]}}, spd2_ff};
      TCS_IDX_SPD_CMD_3: rd_val = {{16{spd3_ff[15]}}, spd3_ff};
      TCS_IDX_MODE: rd_val = {24'h000000, mode_ff};
      TCS_IDX_LPF: rd_val = {28'h0000000, lpf_ff};
      TCS_IDX_STATUS: rd_val = {24'h000000, pulse_position_active, loop_cur, pins_s};
      TCS_IDX_TRQ_OUT: rd_val = {{16{torque_out_ff[15]}}, torque_out_ff};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_comb begin
    nxt_wr_pend = addr_ok && hwrite;
    nxt_wr_idx = addr_ok ? a_idx : wr_idx_ff;
    nxt_hrdata = (addr_ok && !hwrite) ? rd_val : hrdata_ff;
    nxt_full_scale = full_scale_ff;
    nxt_trq1 = trq1_ff;
    nxt_trq2 = trq2_ff;
    nxt_trq3 = trq3_ff;
    nxt_speed_source_sel1 = speed_source_sel1_ff;
    nxt_spd2 = spd2_ff;
    nxt_spd3 = spd3_ff;
    nxt_mode = mode_ff;
    nxt_lpf = lpf_ff;
    if (wr_pend_ff) begin
      unique case (wr_idx_ff)
        TCS_IDX_FULL_SCALE: begin
          // Out-of-range writes saturate at the top of the range
          nxt_full_scale = (hwdata[15:0] > TCS_MAX_FULL_SCALE) ? TCS_MAX_FULL_SCALE
                           : hwdata[15:0];
        end
        TCS_IDX_TRQ_CMD_1: nxt_trq1 = clamp_trq(wval);
        TCS_IDX_TRQ_CMD_2: nxt_trq2 = clamp_trq(wval);
        TCS_IDX_TRQ_CMD_3: nxt_trq3 = clamp_trq(wval);
        TCS_IDX_SPD_CMD_1: nxt_speed_source_sel1 = hwdata[15:0];
        TCS_IDX_SPD_CMD_2: nxt_spd2 = hwdata[15:0];
        TCS_IDX_SPD_CMD_3: nxt_spd3 = hwdata[15:0];
        TCS_IDX_MODE: begin
          if (mode_legal(hwdata[7:0])) begin
            nxt_mode = hwdata[7:0];
          end
        end
        TCS_IDX_LPF: nxt_lpf = hwdata[3:0];
        default: begin
        end
      endcase
    end
    if (!reset_n) begin
      nxt_wr_pend = 1'b0;
      nxt_wr_idx = 12'h000;
      nxt_hrdata = 32'h0000_0000;
      nxt_full_scale = TCS_RST_FULL_SCALE;
      nxt_trq1 = TCS_RST_CMD;
      nxt_trq2 = TCS_RST_CMD;
      nxt_trq3 = TCS_RST_CMD;
      nxt_speed_source_sel1 = TCS_RST_CMD;
      nxt_spd2 = TCS_RST_CMD;
      nxt_spd3 = TCS_RST_CMD;
      nxt_mode = TCS_RST_MODE;
      nxt_lpf = TCS_RST_LPF;
    end
  end

  always_ff @(posedge clk) begin
    wr_pend_ff <= nxt_wr_pend;
    wr_idx_ff <= nxt_wr_idx;
    hrdata_ff <= nxt_hrdata;
    full_scale_ff <= nxt_full_scale;
    trq1_ff <= nxt_trq1;
    trq2_ff <= nxt_trq2;
    trq3_ff <= nxt_trq3;
    speed_source_sel1_ff <= nxt_speed_source_sel1;
    spd2_ff <= nxt_spd2;
    spd3_ff <= nxt_spd3;
    mode_ff <= nxt_mode;
    lpf_ff <= nxt_lpf;
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Active loop from mode code and dual-mode switch input
  tcs_loop_t loop_sel;
  always_comb begin
    loop_sel = TCS_LOOP_POS;
    unique case (mode_ff)
      TCS_MODE_S, TCS_MODE_SZ: loop_sel = TCS_LOOP_SPD;
      TCS_MODE_T, TCS_MODE_TZ: loop_sel = TCS_LOOP_TRQ;
      TCS_MODE_PT_S: loop_sel = sw_on ? TCS_LOOP_SPD : TCS_LOOP_POS;
      TCS_MODE_PT_T: loop_sel = sw_on ? TCS_LOOP_TRQ : TCS_LOOP_POS;
      TCS_MODE_S_T: loop_sel = sw_on ? TCS_LOOP_TRQ : TCS_LOOP_SPD;
      default: loop_sel = TCS_LOOP_POS;
    endcase
  end
  assign loop_cur = loop_sel;
  assign active_loop = loop_cur;

  // Pulse train is the position source in both position dual modes
  assign pulse_position_active = (loop_sel == TCS_LOOP_POS);

  // Analog scaling in 0.1 % units: code * fs * 10 / 32767, so 10 V at fs 100 gives 1000
  logic signed [33:0] prod;
  logic signed [33:0] scaled;
  logic signed [15:0] analog_scaled;
  always_comb begin
    prod = 34'(analog_torque_in) * $signed({18'h00000, full_scale_ff}) * 34'sd10;
    scaled = prod / 34'(TCS_ADC_FULL);
    if (scaled > 34'sd32767) begin
      analog_scaled = 16'sh7FFF;
    end else if (scaled < -34'sd32768) begin
      analog_scaled = 16'sh8000;
    end else begin
      analog_scaled = scaled[15:0];
    end
  end

  logic signed [15:0] analog_filt;
  tcs_lpf u_lpf (
    .clk(clk),
    .reset_n(reset_n),
    .shift(lpf_ff),
    .x(analog_scaled),
    .y(analog_filt)
  );

  logic zero_torque_mode;
  logic signed [15:0] nxt_torque_out;
  logic signed [15:0] speed_out_ff;
  logic signed [15:0] nxt_speed_out;
  logic limit_ff;
  logic nxt_limit;
  assign zero_torque_mode = (mode_ff == TCS_MODE_TZ);

  always_comb begin
    unique case (tsel)
      2'b00: nxt_torque_out = zero_torque_mode ? 16'sh0000 : analog_filt;
      2'b01: nxt_torque_out = trq1_ff;
      2'b10: nxt_torque_out = trq2_ff;
      2'b11: nxt_torque_out = trq3_ff;
    endcase
    unique case (ssel)
      2'b00: nxt_speed_out = (mode_ff == TCS_MODE_SZ) ? 16'sh0000 : analog_speed_in;
      2'b01: nxt_speed_out = speed_source_sel1_ff;
      2'b10: nxt_speed_out = spd2_ff;
      2'b11: nxt_speed_out = spd3_ff;
    endcase
    nxt_limit = (loop_sel != TCS_LOOP_TRQ);
    if (!reset_n) begin
      nxt_torque_out = 16'sh0000;
      nxt_speed_out = 16'sh0000;
      nxt_limit = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    torque_out_ff <= nxt_torque_out;
    speed_out_ff <= nxt_speed_out;
    limit_ff <= nxt_limit;
  end

  assign torque_cmd = torque_out_ff;
  assign speed_cmd = speed_out_ff;
  assign torque_is_limit = limit_ff;

  property p_zero_torque;
    @(posedge clk) disable iff (!reset_n)
      (zero_torque_mode && tsel == 2'b00) |=> (torque_cmd == 16'sh0000);
  endproperty
  a_zero_torque: assert property (p_zero_torque) else $error("zero torque not zero");

  property p_stored;
    @(posedge clk) disable iff (!reset_n)
      (tsel == 2'b10 && !wr_pend_ff) |=> (torque_cmd == $past(trq2_ff));
  endproperty
  a_stored: assert property (p_stored) else $error("stored torque 2 not used");

  property p_sync;
    @(posedge clk) disable iff (!reset_n)
      $rose(torque_source_sel0) ##1 torque_source_sel0 [*2] |-> pins_s[0];
  endproperty
  a_sync: assert property (p_sync) else $error("select not synchronised");

  property p_fs_range;
    @(posedge clk) disable iff (!reset_n) full_scale_ff <= TCS_MAX_FULL_SCALE;
  endproperty
  a_fs_range: assert property (p_fs_range) else $error("full scale above range");

  property p_st_dual;
    @(posedge clk) disable iff (!reset_n)
      (mode_ff == TCS_MODE_S_T) |-> (active_loop == (sw_on ? 2'd2 : 2'd1));
  endproperty
  a_st_dual: assert property (p_st_dual) else $error("speed/torque switch wrong");

  property p_limit;
    @(posedge clk) disable iff (!reset_n)
      (loop_sel == TCS_LOOP_SPD) |=> torque_is_limit;
  endproperty
  a_limit: assert property (p_limit) else $error("speed loop torque not limit");

  property p_pulse;
    @(posedge clk) disable iff (!reset_n)
      (mode_ff == TCS_MODE_PT_T && !sw_on) |-> pulse_position_active;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse position not active");

  property p_mode_legal;
    @(posedge clk) disable iff (!reset_n) mode_legal(mode_ff);
  endproperty
  a_mode_legal: assert property (p_mode_legal) else $error("illegal mode code");

  property p_trq_range;
    @(posedge clk) disable iff (!reset_n)
      $signed(trq1_ff) <= TCS_TRQ_LIMIT && $signed(trq1_ff) >= -TCS_TRQ_LIMIT;
  endproperty
  a_trq_range: assert property (p_trq_range) else $error("stored torque out of range");
endmodule : tcs_top

// *** src/tcs_pkg.sv ***
// Package of constants and types for the torque command selector
package tcs_pkg;
  // Register word indices; the byte address on the bus is four times the index
  localparam logic [11:0] TCS_IDX_FULL_SCALE = 12'h152;
  localparam logic [11:0] TCS_IDX_TRQ_CMD_1 = 12'h112;
  localparam logic [11:0] TCS_IDX_TRQ_CMD_2 = 12'h113;
  localparam logic [11:0] TCS_IDX_TRQ_CMD_3 = 12'h114;
  localparam logic [11:0] TCS_IDX_SPD_CMD_1 = 12'h109;
  localparam logic [11:0] TCS_IDX_SPD_CMD_2 = 12'h10A;
  localparam logic [11:0] TCS_IDX_SPD_CMD_3 = 12'h10B;
  localparam logic [11:0] TCS_IDX_MODE = 12'h101;
  localparam logic [11:0] TCS_IDX_STATUS = 12'h200;
  localparam logic [11:0] TCS_IDX_TRQ_OUT = 12'h201;
  localparam logic [11:0] TCS_IDX_LPF = 12'h202;
  // Reset values and the full-scale maximum
  localparam logic [15:0] TCS_RST_FULL_SCALE = 16'h0064;
  localparam logic [15:0] TCS_MAX_FULL_SCALE = 16'h03E8;
  localparam logic [15:0] TCS_RST_CMD = 16'h0000;
  localparam logic [7:0] TCS_RST_MODE = 8'h02;
  localparam logic [3:0] TCS_RST_LPF = 4'h4;
  // Stored torque commands in 0.1 % units: +/-300 % is +/-3000
  localparam logic signed [15:0] TCS_TRQ_LIMIT = 16'sh0BB8;
  // Analog code full scale: +/-10 V maps to +/-32767
  localparam int TCS_ADC_FULL = 32767;
  // Control mode setting codes
  localparam logic [7:0] TCS_MODE_PT = 8'h00;
  localparam logic [7:0] TCS_MODE_S = 8'h02;
  localparam logic [7:0] TCS_MODE_T = 8'h03;
  localparam logic [7:0] TCS_MODE_SZ = 8'h04;
  localparam logic [7:0] TCS_MODE_TZ = 8'h05;
  localparam logic [7:0] TCS_MODE_PT_S = 8'h06;
  localparam logic [7:0] TCS_MODE_PT_T = 8'h07;
  localparam logic [7:0] TCS_MODE_S_T = 8'h0A;
  // Active loop, as decided by mode code and switch input
  typedef enum logic [1:0] {
    TCS_LOOP_POS,
    TCS_LOOP_SPD,
    TCS_LOOP_TRQ
  } tcs_loop_t;
endpackage : tcs_pkg

// *** src/tcs_sync.sv ***
// Two-flop synchroniser for one level input
`timescale 1ns/10ps
module tcs_sync (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic din,
  output logic dout
);
  logic meta_ff;
  logic sync_ff;
  logic nxt_meta;
  logic nxt_sync;

  always_comb begin
    nxt_meta = reset_n ? din : 1'b0;
    nxt_sync = reset_n ? meta_ff : 1'b0;
  end

  always_ff @(posedge clk) begin
    meta_ff <= nxt_meta;
    sync_ff <= nxt_sync;
  end

  assign dout = sync_ff;
endmodule : tcs_sync

// *** src/tcs_lpf.sv ***
// First-order low-pass filter, y += (x - y) >> shift
`timescale 1ns/10ps
module tcs_lpf (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] shift,
  input wire logic signed [15:0] x,
  output logic signed [15:0] y
);
  logic signed [23:0] acc_ff;
  logic signed [23:0] nxt_acc;
  logic signed [24:0] diff;

  // One guard bit keeps a full-swing step from wrapping the difference
  always_comb begin
    diff = $signed({x[15], x, 8'h00}) - $signed({acc_ff[23], acc_ff});
    nxt_acc = reset_n ? acc_ff + 24'(diff >>> shift) : 24'sh000000;
  end

  always_ff @(posedge clk) begin
    acc_ff <= nxt_acc;
  end

  assign y = acc_ff[23:8];
endmodule : tcs_lpf

// *** verif/tcs_host_model.sv ***
// Host motion controller model driving the select and mode-switch lines
`timescale 1ns/10ps
module tcs_host_model (
  input wire logic clk,
  input wire logic servo_on,
  input wire logic [1:0] req_tsel,
  input wire logic [1:0] req_ssel,
  input wire logic req_sw,
  output logic tsel0,
  output logic tsel1,
  output logic ssel0,
  output logic ssel1,
  output logic sw
);
  initial begin
    {tsel1, tsel0, ssel1, ssel0, sw} = 5'h00;
  end
  // Lines are only set once the drive is servo-on; a closed contact drives 1
  always @(posedge clk) begin
    if (servo_on) begin
      {tsel1, tsel0} <= req_tsel;
      {ssel1, ssel0} <= req_ssel;
      sw <= req_sw;
    end
  end
endmodule : tcs_host_model

// *** verif/torque_command_selector_test.sv ***
// Self-checking bench for the torque command selector
`timescale 1ns/10ps
module torque_command_selector_test
  import tcs_pkg::*;
;
  typedef struct packed {
    logic [7:0] mode;
    logic [1:0] tsel;
    logic sw;
    logic [15:0] trq;
    tcs_loop_t lp;
    logic lim;
    logic pp;
  } tcs_row_t;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic servo_on = 1'b0;
  logic [1:0] req_tsel = 2'h0;
  logic [1:0] req_ssel = 2'h0;
  logic req_sw = 1'b0;
  logic tsel0, tsel1, ssel0, ssel1, sw;
  logic signed [15:0] ana = 16'sh0000;
  logic signed [15:0] spd_ana = 16'sh0000;
  logic signed [15:0] torque_cmd, speed_cmd;
  logic torque_is_limit, pulse_position_active;
  logic [1:0] active_loop;
  int miscompares = 0;
  int checks = 0;
  tcs_row_t rows [15];
  logic [31:0] rd;
  logic ok;
  always #12.5 clk = ~clk;
  tcs_host_model u_host (.clk(clk), .servo_on(servo_on), .req_tsel(req_tsel),
    .req_ssel(req_ssel), .req_sw(req_sw), .tsel0(tsel0), .tsel1(tsel1),
    .ssel0(ssel0), .ssel1(ssel1), .sw(sw));
  tcs_top u_dut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .torque_source_sel0(tsel0), .torque_source_sel1(tsel1),
    .speed_source_sel0(ssel0), .speed_source_sel1(ssel1), .mode_switch_in(sw),
    .analog_torque_in(ana), .analog_speed_in(spd_ana), .torque_cmd(torque_cmd),
    .torque_is_limit(torque_is_limit), .speed_cmd(speed_cmd),
    .pulse_position_active(pulse_position_active), .active_loop(active_loop));
  task automatic conclude();
    if (miscompares == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_reg
  task automatic chk_port(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_port
  // Bounded wait for the edge where hready is sampled high
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 64) begin
        miscompares++;
        conclude();
      end
      @(posedge clk);
    end
  endtask : wait_rdy
  task automatic bus(input logic w, input logic [11:0] idx, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {18'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : bus
  task automatic rchk(input string nm, input logic [11:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 32'h0);
    chk_reg(nm, e, rd);
    chk_reg("hresp", 32'h0, {31'h0, hresp});
  endtask : rchk
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  initial begin
    rows = '{
      '{8'h03, 2'b01, 1'b0, 16'h0064, TCS_LOOP_TRQ, 1'b0, 1'b0},
      '{8'h03, 2'b10, 1'b0, 16'hFF38, TCS_LOOP_TRQ, 1'b0, 1'b0},
      '{8'h03, 2'b11, 1'b0, 16'h0BB8, TCS_LOOP_TRQ, 1'b0, 1'b0},
      '{8'h03, 2'b00, 1'b0, 16'h03E8, TCS_LOOP_TRQ, 1'b0, 1'b0},
      '{8'h05, 2'b00, 1'b0, 16'h0000, TCS_LOOP_TRQ, 1'b0, 1'b0},
      '{8'h05, 2'b11, 1'b0, 16'h0BB8, TCS_LOOP_TRQ, 1'b0, 1'b0},
      '{8'h02, 2'b00, 1'b0, 16'h03E8, TCS_LOOP_SPD, 1'b1, 1'b0},
      '{8'h02, 2'b01, 1'b0, 16'h0064, TCS_LOOP_SPD, 1'b1, 1'b0},
      '{8'h00, 2'b10, 1'b0, 16'hFF38, TCS_LOOP_POS, 1'b1, 1'b1},
      '{8'h0A, 2'b01, 1'b1, 16'h0064, TCS_LOOP_TRQ, 1'b0, 1'b0},
      '{8'h0A, 2'b01, 1'b0, 16'h0064, TCS_LOOP_SPD, 1'b1, 1'b0},
      '{8'h06, 2'b01, 1'b1, 16'h0064, TCS_LOOP_SPD, 1'b1, 1'b0},
      '{8'h06, 2'b01, 1'b0, 16'h0064, TCS_LOOP_POS, 1'b1, 1'b1},
      '{8'h07, 2'b01, 1'b1, 16'h0064, TCS_LOOP_TRQ, 1'b0, 1'b0},
      '{8'h07, 2'b01, 1'b0, 16'h0064, TCS_LOOP_POS, 1'b1, 1'b1}};
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    servo_on <= 1'b1;
    settle(2);
    chk_port("torque_cmd", 16'h0000, torque_cmd);
    chk_port("active_loop", 16'h0001, {14'h0, active_loop});
    rchk("full_scale", TCS_IDX_FULL_SCALE, 32'h0000_0064);
    rchk("mode", TCS_IDX_MODE, 32'h0000_0002);
    rchk("unmapped", 12'h3FF, 32'h0000_0000);
    bus(1'b1, TCS_IDX_TRQ_CMD_1, 32'h0000_0064);
    bus(1'b1, TCS_IDX_TRQ_CMD_2, 32'hFFFF_FF38);
    bus(1'b1, TCS_IDX_TRQ_CMD_3, 32'h0000_0FA0);
    rchk("trq_cmd_2", TCS_IDX_TRQ_CMD_2, 32'hFFFF_FF38);
    rchk("trq_cmd_3", TCS_IDX_TRQ_CMD_3, 32'h0000_0BB8);
    bus(1'b1, TCS_IDX_LPF, 32'h0);
    ana <= 16'sh7FFF;
    foreach (rows[i]) begin
      bus(1'b1, TCS_IDX_MODE, {24'h0, rows[i].mode});
      req_tsel <= rows[i].tsel;
      req_sw <= rows[i].sw;
      settle(8);
      chk_port("torque_cmd", rows[i].trq, torque_cmd);
      chk_port("active_loop", {14'h0, rows[i].lp}, {14'h0, active_loop});
      chk_port("torque_is_limit", {15'h0, rows[i].lim}, {15'h0, torque_is_limit});
      chk_port("pulse_pos", {15'h0, rows[i].pp}, {15'h0, pulse_position_active});
    end
    // Full scale saturates at 1000 %, and ten volts then gives ten times rated
    bus(1'b1, TCS_IDX_FULL_SCALE, 32'h0000_04B0);
    rchk("full_scale", TCS_IDX_FULL_SCALE, 32'h0000_03E8);
    bus(1'b1, TCS_IDX_MODE, 32'h0000_0003);
    req_tsel <= 2'b00;
    settle(8);
    chk_port("torque_cmd", 16'h2710, torque_cmd);
    bus(1'b1, TCS_IDX_FULL_SCALE, 32'h0);
    settle(8);
    chk_port("torque_cmd", 16'h0000, torque_cmd);
    bus(1'b1, TCS_IDX_MODE, 32'h0000_0009);
    rchk("mode", TCS_IDX_MODE, 32'h0000_0003);
    // Step response through the filter: partial after a few cycles, settled later
    bus(1'b1, TCS_IDX_FULL_SCALE, 32'h0000_0064);
    bus(1'b1, TCS_IDX_LPF, 32'h0000_0004);
    ana <= 16'sh0000;
    settle(300);
    @(posedge clk);
    ana <= 16'sh7FFF;
    settle(6);
    ok = (torque_cmd > 16'sd0) && (torque_cmd < 16'sd1000);
    chk_port("lpf_mid", 16'h0001, {15'h0, ok});
    settle(300);
    ok = (torque_cmd >= 16'sd985) && (torque_cmd <= 16'sd1000);
    chk_port("lpf_end", 16'h0001, {15'h0, ok});
    // Speed side of the speed/torque dual mode
    bus(1'b1, TCS_IDX_SPD_CMD_1, 32'h0000_01F4);
    bus(1'b1, TCS_IDX_MODE, 32'h0000_000A);
    req_sw <= 1'b0;
    req_ssel <= 2'b01;
    settle(8);
    chk_port("speed_cmd", 16'h01F4, speed_cmd);
    @(posedge clk);
    req_ssel <= 2'b00;
    spd_ana <= 16'sh0123;
    settle(8);
    chk_port("speed_cmd", 16'h0123, speed_cmd);
    // Reset in mid-run brings registers and outputs back to their reset values
    @(posedge clk);
    reset_n <= 1'b0;
    settle(3);
    chk_port("torque_cmd", 16'h0000, torque_cmd);
    chk_port("speed_cmd", 16'h0000, speed_cmd);
    chk_port("torque_is_limit", 16'h0000, {15'h0, torque_is_limit});
    @(posedge clk);
    reset_n <= 1'b1;
    rchk("full_scale", TCS_IDX_FULL_SCALE, 32'h0000_0064);
    rchk("spd_cmd_1", TCS_IDX_SPD_CMD_1, 32'h0000_0000);
    chk_port("active_loop", 16'h0001, {14'h0, active_loop});
    conclude();
  end
endmodule : torque_command_selector_test
